// ==== core/rtcam_osc_if.sv ====
// rtcam_osc_if: oscillator-edge and monitor signals between top and monitor
// assumes one clock domain
`timescale 1ns/1ps
interface rtcam_osc_if;
  logic oscEdge;
  logic oscLevel;
  logic mcdEnable;
  logic oscEnable;
  logic failEvent;
  logic xtalValid;
  modport mon (input oscLevel, oscEnable, mcdEnable, output oscEdge, failEvent, xtalValid);
  modport top (output oscLevel, oscEnable, mcdEnable, input oscEdge, failEvent, xtalValid);
endinterface : rtcam_osc_if

// ==== core/rtcam_osc_monitor.sv ====
// rtcam_osc_monitor: oscillator edge detect, missing-clock timer, valid blanking
// assumes oscillator level and amplitude input already synchronous to clock
`timescale 1ns/1ps
module rtcam_osc_monitor #(
  parameter int MISS_CYCLES = rtcam_pkg::MISSING_CYCLES,
  parameter int BLANK_CYCLES = rtcam_pkg::BLANK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic amplitudeOk,
  rtcam_osc_if.mon osc
);
  logic lastLevel_reg, lastLevel_next;
  logic [13:0] missCount_reg, missCount_next;
  logic [18:0] blankCount_reg, blankCount_next;
  logic armed_reg, armed_next;
  logic valid_reg, valid_next;
  logic edgeNow;

  // next-state for edge detect, one-shot miss timer and blanking
  always_comb begin
    edgeNow = osc.oscLevel != lastLevel_reg;
    lastLevel_next = osc.oscLevel;
    missCount_next = missCount_reg;
    armed_next = armed_reg;
    blankCount_next = blankCount_reg;
    valid_next = 1'b0;
    if (!osc.mcdEnable) begin // [R01]
      missCount_next = '0;
      armed_next = 1'b1;
    end else if (edgeNow) begin
      missCount_next = '0;
    end else if (armed_reg && missCount_reg < 14'(MISS_CYCLES)) begin
      missCount_next = missCount_reg + 14'd1;
    end else if (armed_reg) begin
      armed_next = 1'b0; // one-shot until re-enabled [R01]
    end
    if (!osc.oscEnable) begin
      blankCount_next = '0;
    end else if (blankCount_reg < 19'(BLANK_CYCLES)) begin
      blankCount_next = blankCount_reg + 19'd1;
    end else begin
      valid_next = amplitudeOk; // masked low during blanking [R05] [R06]
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      lastLevel_reg <= 1'b0;
      missCount_reg <= '0;
      armed_reg <= 1'b1;
      blankCount_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      lastLevel_reg <= lastLevel_next;
      missCount_reg <= missCount_next;
      armed_reg <= armed_next;
      blankCount_reg <= blankCount_next;
      valid_reg <= valid_next;
    end
  end

  assign osc.oscEdge = edgeNow && osc.oscLevel;
  // stuck level longer than the limit fires once [R02]
  assign osc.failEvent = osc.mcdEnable && armed_reg && !edgeNow
    && missCount_reg >= 14'(MISS_CYCLES);
  assign osc.xtalValid = valid_reg;

  chk_valid_blanked: assert property (@(posedge clock) disable iff (!rst_b) // [R06]
    (blankCount_reg < 19'(BLANK_CYCLES)) |=> !valid_reg) else $error("valid during blanking");
  chk_fail_one_shot: assert property (@(posedge clock) disable iff (!rst_b) // [R01]
    osc.failEvent |=> !osc.failEvent) else $error("fail event repeated");
  chk_fail_needs_enable: assert property (@(posedge clock) disable iff (!rst_b) // [R02]
    osc.failEvent |-> osc.mcdEnable && missCount_reg >= 14'(MISS_CYCLES))
    else $error("fail without enable or timeout");
endmodule : rtcam_osc_monitor

// ==== core/rtcam_pkg.sv ====
// rtcam_pkg: register indices, field positions, reset values and timing counts
// assumes a 125 MHz system clock and a low-frequency oscillator sampled on it
package rtcam_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_HOLD0 = 4'h0;
  localparam logic [3:0] ADDR_HOLD3 = 4'h3;
  localparam logic [3:0] ADDR_ALARM0 = 4'h4;
  localparam logic [3:0] ADDR_ALARM3 = 4'h7;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_OSC = 4'h9;
  // control register field positions
  localparam int BIT_OSC_ENABLE = 7;
  localparam int BIT_MCD_ENABLE = 6;
  localparam int BIT_OSC_FAIL = 5;
  localparam int BIT_RUN = 4;
  localparam int BIT_ALARM_EN = 3;
  localparam int BIT_ALARM_FLAG = 2;
  localparam int BIT_SET_REQ = 1;
  localparam int BIT_CAP_REQ = 0;
  // oscillator register field position
  localparam int BIT_XTAL_VALID = 4;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  // timing
  localparam int CLOCK_MHZ = 125;
  localparam int MISSING_US = 100;
  localparam int MISSING_CYCLES = MISSING_US * CLOCK_MHZ;
  localparam int BLANK_MS = 2;
  localparam int BLANK_CYCLES = BLANK_MS * 1000 * CLOCK_MHZ;
  // transfer engine states
  typedef enum logic [1:0] {XFER_IDLE, XFER_SET, XFER_CAP} rtcam_xfer_e;
endpackage : rtcam_pkg

// ==== core/rtcam_top.sv ====
// rtcam_top: 32-bit oscillator-clocked counter, set/capture transfer, alarm
// and missing-clock monitor behind a plain register port
// assumes all inputs synchronous to clock; oscLevel is the sampled oscillator
// What this block does and what software must do
// [R01] missing-clock detector is a one-shot that runs only while enabled
// [R02] enabled detector sets oscillator fail flag after 100 us stuck level
// [R03] detector timeout drives interrupt and wake-up outputs
// [R04] software disables the detector before changing oscillator settings
// [R05] crystal-valid reports oscillation started; startup use only
// [R06] crystal-valid is meaningless for 2 ms after oscillator turns on
// [R07] counter increments once per oscillator cycle while run bit is 1
// [R08] run bit 0 holds the counter value
// [R09] counter wraps from maximum to zero and keeps counting
// [R10] writing the alarm-flag position sets or clears auto-reset only
// [R11] reading the alarm-flag position returns the alarm event flag
// [R12] auto-reset clears the counter one oscillator cycle after a match
// [R13] software programs compare one below interval when using auto-reset
// [R14] set and capture work while the counter runs
// [R15] set request loads holding bytes into counter, then self-clears
// [R16] capture request snapshots counter into holding bytes, then self-clears
// [R17] software writes holding bytes, sets set-request, polls for zero
// [R18] software sets capture-request, polls for zero, reads holding bytes
// [R19] alarm event when counter equals the 32-bit compare value
// [R20] alarm event drives interrupt and wake-up outputs
// [R21] software clears alarm-enable, writes compare, then sets alarm-enable
// [R22] writing alarm-enable 0 clears the alarm event flag
// [R23] re-enable without new compare matches again 2^32 cycles later
// [R24] alarm flag lasts at most one oscillator cycle; pending latches it
// [R25] holding and compare values are byte registers, low byte first
`timescale 1ns/1ps
module rtcam_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic oscLevel,
  input wire logic amplitudeOk,
  input wire logic pendingClear,
  output logic oscEnable,
  output logic irqPending,
  output logic wakeRequest
);
  rtcam_osc_if osc ();

  logic [7:0] ctrl_reg, ctrl_next;
  logic autoReset_reg, autoReset_next;
  logic alarmFlag_reg, alarmFlag_next;
  logic oscillator_fail_flag_reg, oscillator_fail_flag_next;
  logic clearPending_reg, clearPending_next;
  logic [31:0] count_reg, count_next;
  logic [7:0] hold_reg [4];
  logic [7:0] hold_next [4];
  logic [7:0] alarm_reg [4];
  logic [7:0] alarm_next [4];
  logic [7:0] rdata_next;
  logic irq_next;
  rtcam_pkg::rtcam_xfer_e xfer_reg, xfer_next;
  logic [31:0] holdWord, alarmWord;
  logic alarmMatch, ctrlWrite;

  // byte index of a register address inside a four-byte group
  function automatic logic [1:0] byte_sel(input logic [3:0] addr);
    byte_sel = addr[1:0];
  endfunction : byte_sel

  // whether the address lies in a four-byte group starting at base
  function automatic logic in_group(input logic [3:0] addr, input logic [3:0] base);
    in_group = addr[3:2] == base[3:2];
  endfunction : in_group

  // pack byte arrays into words, low byte at lowest address
  generate
    for (genvar i = 0; i < 4; i++) begin : g_pack
      assign holdWord[8*i +: 8] = hold_reg[i]; // [R25]
      assign alarmWord[8*i +: 8] = alarm_reg[i]; // [R25]
    end
  endgenerate

  assign ctrlWrite = regWrite && regAddr == rtcam_pkg::ADDR_CTRL;
  // exact 32-bit equality, gated by alarm enable, checked on an oscillator edge
  // equality only, so a re-enable waits for the counter to come round [R23]
  assign alarmMatch = osc.oscEdge && ctrl_reg[rtcam_pkg::BIT_ALARM_EN]
    && count_reg == alarmWord; // [R19] [R23]

  // monitor wiring
  assign osc.oscLevel = oscLevel;
  assign osc.oscEnable = ctrl_reg[rtcam_pkg::BIT_OSC_ENABLE];
  assign osc.mcdEnable = ctrl_reg[rtcam_pkg::BIT_MCD_ENABLE];

  rtcam_osc_monitor u_monitor (
    .clock(clock),
    .rst_b(rst_b),
    .amplitudeOk(amplitudeOk),
    .osc(osc)
  );

  // control register, flags and transfer engine
  always_comb begin
    ctrl_next = ctrl_reg;
    autoReset_next = autoReset_reg;
    alarmFlag_next = 1'b0;
    oscillator_fail_flag_next = oscillator_fail_flag_reg;
    xfer_next = xfer_reg;
    if (ctrlWrite) begin
      ctrl_next = regWdata;
      ctrl_next[rtcam_pkg::BIT_OSC_FAIL] = 1'b0;
      ctrl_next[rtcam_pkg::BIT_ALARM_FLAG] = 1'b0;
      autoReset_next = regWdata[rtcam_pkg::BIT_ALARM_FLAG]; // [R10]
      if (!regWdata[rtcam_pkg::BIT_OSC_FAIL]) begin
        oscillator_fail_flag_next = 1'b0;
      end
    end
    // hardware set of fail flag beats a software clear [R02]
    if (osc.failEvent) begin
      oscillator_fail_flag_next = 1'b1;
    end
    // flag lives for one oscillator cycle only [R24]
    if (alarmMatch) begin
      alarmFlag_next = 1'b1;
    end else if (alarmFlag_reg && !osc.oscEdge) begin
      alarmFlag_next = 1'b1;
    end
    if (ctrlWrite && !regWdata[rtcam_pkg::BIT_ALARM_EN]) begin
      alarmFlag_next = 1'b0; // [R22]
    end
    // one request served at a time; set takes priority over capture
    case (xfer_reg)
      rtcam_pkg::XFER_IDLE: begin
        if (ctrl_reg[rtcam_pkg::BIT_SET_REQ]) begin
          xfer_next = rtcam_pkg::XFER_SET;
        end else if (ctrl_reg[rtcam_pkg::BIT_CAP_REQ]) begin
          xfer_next = rtcam_pkg::XFER_CAP;
        end
      end
      rtcam_pkg::XFER_SET: begin
        ctrl_next[rtcam_pkg::BIT_SET_REQ] = 1'b0; // [R15]
        xfer_next = rtcam_pkg::XFER_IDLE;
      end
      rtcam_pkg::XFER_CAP: begin
        ctrl_next[rtcam_pkg::BIT_CAP_REQ] = 1'b0; // [R16]
        xfer_next = rtcam_pkg::XFER_IDLE;
      end
      default: xfer_next = rtcam_pkg::XFER_IDLE;
    endcase
  end

  // counter, holding and compare bytes
  always_comb begin
    count_next = count_reg;
    clearPending_next = clearPending_reg;
    hold_next = hold_reg;
    alarm_next = alarm_reg;
    if (osc.oscEdge && clearPending_reg) begin
      count_next = rtcam_pkg::COUNT_RESET; // one cycle after match [R12]
      clearPending_next = 1'b0;
    end else if (osc.oscEdge && ctrl_reg[rtcam_pkg::BIT_RUN]) begin
      count_next = count_reg + 32'h0000_0001; // natural wrap [R07] [R09]
    end // otherwise hold [R08]
    if (alarmMatch && autoReset_reg) begin
      clearPending_next = 1'b1;
    end
    // transfers work while running [R14]
    if (xfer_reg == rtcam_pkg::XFER_SET) begin
      count_next = holdWord; // [R15]
      clearPending_next = 1'b0;
    end
    if (xfer_reg == rtcam_pkg::XFER_CAP) begin
      for (int i = 0; i < 4; i++) begin
        hold_next[i] = count_reg[8*i +: 8]; // [R16]
      end
    end else if (regWrite && in_group(regAddr, rtcam_pkg::ADDR_HOLD0)) begin
      hold_next[byte_sel(regAddr)] = regWdata; // [R25]
    end
    if (regWrite && in_group(regAddr, rtcam_pkg::ADDR_ALARM0)) begin
      alarm_next[byte_sel(regAddr)] = regWdata; // [R25]
    end
  end

  // read mux and event outputs
  always_comb begin
    rdata_next = 8'h00;
    if (regRead) begin
      if (in_group(regAddr, rtcam_pkg::ADDR_HOLD0)) begin
        rdata_next = hold_reg[byte_sel(regAddr)];
      end else if (in_group(regAddr, rtcam_pkg::ADDR_ALARM0)) begin
        rdata_next = alarm_reg[byte_sel(regAddr)];
      end else if (regAddr == rtcam_pkg::ADDR_CTRL) begin
        rdata_next = ctrl_reg;
        rdata_next[rtcam_pkg::BIT_OSC_FAIL] = oscillator_fail_flag_reg;
        rdata_next[rtcam_pkg::BIT_ALARM_FLAG] = alarmFlag_reg; // [R11]
      end else if (regAddr == rtcam_pkg::ADDR_OSC) begin
        rdata_next[rtcam_pkg::BIT_XTAL_VALID] = osc.xtalValid; // [R05]
      end
    end
    // sticky pending; a new event beats the clear [R03] [R20] [R24]
    irq_next = irqPending;
    if (pendingClear) begin
      irq_next = 1'b0;
    end
    if (alarmMatch || osc.failEvent) begin
      irq_next = 1'b1;
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_reg <= rtcam_pkg::CTRL_RESET;
      autoReset_reg <= 1'b0;
      alarmFlag_reg <= 1'b0;
      oscillator_fail_flag_reg <= 1'b0;
      clearPending_reg <= 1'b0;
      count_reg <= rtcam_pkg::COUNT_RESET;
      xfer_reg <= rtcam_pkg::XFER_IDLE;
      regRdata <= 8'h00;
      irqPending <= 1'b0;
      wakeRequest <= 1'b0;
      oscEnable <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        hold_reg[i] <= 8'h00;
        alarm_reg[i] <= 8'h00;
      end
    end else begin
      ctrl_reg <= ctrl_next;
      autoReset_reg <= autoReset_next;
      alarmFlag_reg <= alarmFlag_next;
      oscillator_fail_flag_reg <= oscillator_fail_flag_next;
      clearPending_reg <= clearPending_next;
      count_reg <= count_next;
      xfer_reg <= xfer_next;
      regRdata <= rdata_next;
      irqPending <= irq_next;
      wakeRequest <= irq_next; // [R03] [R20]
      oscEnable <= ctrl_next[rtcam_pkg::BIT_OSC_ENABLE];
      hold_reg <= hold_next;
      alarm_reg <= alarm_next;
    end
  end

  // named steps for the auto-reset sequence
  sequence s_match_auto;
    alarmMatch && autoReset_reg && xfer_reg == rtcam_pkg::XFER_IDLE
      && !(ctrl_reg[rtcam_pkg::BIT_SET_REQ]);
  endsequence
  sequence s_pending_edge;
    osc.oscEdge && clearPending_reg && xfer_reg != rtcam_pkg::XFER_SET;
  endsequence
  sequence s_count_zero;
    count_reg == 32'h0000_0000;
  endsequence

  chk_count_step: assert property (@(posedge clock) disable iff (!rst_b) // [R07]
    osc.oscEdge && ctrl_reg[rtcam_pkg::BIT_RUN] && !clearPending_reg
      && xfer_reg != rtcam_pkg::XFER_SET |=> count_reg == $past(count_reg) + 32'h0000_0001)
    else $error("counter did not step");
  chk_count_hold: assert property (@(posedge clock) disable iff (!rst_b) // [R08]
    !ctrl_reg[rtcam_pkg::BIT_RUN] && !clearPending_reg && xfer_reg != rtcam_pkg::XFER_SET
      |=> $stable(count_reg)) else $error("stopped counter moved");
  chk_wrap_zero: assert property (@(posedge clock) disable iff (!rst_b) // [R09]
    osc.oscEdge && ctrl_reg[rtcam_pkg::BIT_RUN] && count_reg == 32'hFFFF_FFFF
      && !clearPending_reg && xfer_reg != rtcam_pkg::XFER_SET |=> count_reg == 32'h0000_0000)
    else $error("counter did not wrap");
  chk_auto_clear: assert property (@(posedge clock) disable iff (!rst_b) // [R12]
    s_match_auto |=> clearPending_reg) else $error("auto-reset not armed");
  chk_auto_zero: assert property (@(posedge clock) disable iff (!rst_b) // [R12]
    s_pending_edge |=> s_count_zero) else $error("auto-reset did not clear counter");
  chk_set_load: assert property (@(posedge clock) disable iff (!rst_b) // [R15]
    xfer_reg == rtcam_pkg::XFER_SET |=> count_reg == $past(holdWord)
      && !ctrl_reg[rtcam_pkg::BIT_SET_REQ]) else $error("set load wrong");
  chk_cap_snap: assert property (@(posedge clock) disable iff (!rst_b) // [R16]
    xfer_reg == rtcam_pkg::XFER_CAP |=> holdWord == $past(count_reg)
      && !ctrl_reg[rtcam_pkg::BIT_CAP_REQ]) else $error("capture wrong");
  chk_req_done: assert property (@(posedge clock) disable iff (!rst_b) // [R14]
    ctrl_reg[rtcam_pkg::BIT_SET_REQ] && !ctrlWrite |-> ##[1:2] !ctrl_reg[rtcam_pkg::BIT_SET_REQ])
    else $error("set request stuck");
  chk_disable_clear: assert property (@(posedge clock) disable iff (!rst_b) // [R22]
    ctrlWrite && !regWdata[rtcam_pkg::BIT_ALARM_EN] |=> !alarmFlag_reg)
    else $error("alarm flag survived disable");
  chk_irq_latch: assert property (@(posedge clock) disable iff (!rst_b) // [R24]
    alarmMatch |=> irqPending && wakeRequest) else $error("alarm not latched");
  chk_fail_flag: assert property (@(posedge clock) disable iff (!rst_b) // [R02]
    osc.failEvent |=> oscillator_fail_flag_reg && irqPending) else $error("fail not flagged");
endmodule : rtcam_top

// ==== verification/rtcam_top_tb.sv ====
// rtcam_top_tb: self-checking bench for the counter, transfer path, alarm and clock monitor
// assumes rtcam_top and rtcam_pkg compiled first; 125 MHz clock, bench drives all ports
`timescale 1ns/1ps
module rtcam_top_tb;
  localparam logic [7:0] M_OSC = 8'h80;
  localparam logic [7:0] M_MCD = 8'h40;
  localparam logic [7:0] M_RUN = 8'h10;
  localparam logic [7:0] M_AEN = 8'h08;
  localparam logic [7:0] M_ARS = 8'h04;
  localparam logic [7:0] M_SET = 8'h02;
  localparam logic [7:0] M_CAP = 8'h01;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic oscLevel = 1'b0;
  logic amplitudeOk = 1'b1;
  logic pendingClear = 1'b0;
  logic oscEnable;
  logic irqPending;
  logic wakeRequest;
  logic [7:0] ctrlNow = 8'h00;
  logic [7:0] rd;
  logic [31:0] v;
  int error_cnt = 0;
  int n_compared = 0;
  int flags;
  // clock generation, 8 ns period
  always #4 clock = ~clock;
  rtcam_top dut_u (.clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .oscLevel(oscLevel),
    .amplitudeOk(amplitudeOk), .pendingClear(pendingClear), .oscEnable(oscEnable),
    .irqPending(irqPending), .wakeRequest(wakeRequest));
  // compare one value and count it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one-cycle register write
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : reg_write
  // one-cycle read strobe, data taken in the following cycle
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    d = regRdata;
  endtask : reg_read
  // 32-bit values travel as four bytes, low byte first
  task automatic write32(input logic [3:0] base, input logic [31:0] d);
    for (int i = 0; i < 4; i++) reg_write(base + 4'(i), d[8*i +: 8]);
  endtask : write32
  task automatic read32(input logic [3:0] base, output logic [31:0] d);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      reg_read(base + 4'(i), b);
      d[8*i +: 8] = b;
    end
  endtask : read32
  // poll a self-clearing control bit, bounded
  task automatic poll(input int bitPos);
    logic [7:0] c;
    for (int i = 0; i < 20; i++) begin
      reg_read(rtcam_pkg::ADDR_CTRL, c);
      if (c[bitPos] === 1'b0) break;
    end
    check("request bit cleared", 32'(c[bitPos]), 32'h0000_0000);
  endtask : poll
  task automatic set_to(input logic [31:0] d);
    write32(rtcam_pkg::ADDR_HOLD0, d);
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow | M_SET);
    poll(rtcam_pkg::BIT_SET_REQ);
  endtask : set_to
  task automatic capture(output logic [31:0] d);
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow | M_CAP);
    poll(rtcam_pkg::BIT_CAP_REQ);
    read32(rtcam_pkg::ADDR_HOLD0, d);
  endtask : capture
  // n oscillator cycles of 7 clocks; alarm flag sampled in each high phase
  task automatic osc_cycles(input int n, output int f);
    logic [7:0] c;
    f = 0;
    repeat (n) begin
      @(posedge clock);
      oscLevel <= 1'b1;
      reg_read(rtcam_pkg::ADDR_CTRL, c);
      if (c[rtcam_pkg::BIT_ALARM_FLAG] === 1'b1) f++;
      @(posedge clock);
      oscLevel <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask : osc_cycles
  task automatic clear_pending;
    @(posedge clock);
    pendingClear <= 1'b1;
    @(posedge clock);
    pendingClear <= 1'b0;
    @(negedge clock);
  endtask : clear_pending
  task automatic test_reset;
    reg_read(rtcam_pkg::ADDR_CTRL, rd);
    check("control after reset", 32'(rd), 32'(rtcam_pkg::CTRL_RESET));
    check("pending after reset", 32'(irqPending), 32'h0000_0000);
    reg_write(4'hF, 8'hA5);
    reg_read(4'hF, rd);
    check("unmapped read", 32'(rd), 32'h0000_0000);
  endtask : test_reset
  task automatic test_transfer;
    set_to(32'h1234_5678);
    write32(rtcam_pkg::ADDR_HOLD0, 32'h0000_0000);
    osc_cycles(3, flags);
    capture(v);
    check("stopped counter", v, 32'h1234_5678);
    ctrlNow = M_RUN;
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow);
    osc_cycles(5, flags);
    capture(v);
    check("running count", v, 32'h1234_567D);
    set_to(32'h0000_0100);
    osc_cycles(2, flags);
    capture(v);
    check("set while running", v, 32'h0000_0102);
    set_to(32'hFFFF_FFFE);
    osc_cycles(3, flags);
    capture(v);
    check("wrap to zero", v, 32'h0000_0001);
  endtask : test_transfer
  task automatic test_alarm;
    set_to(32'h0000_0000);
    write32(rtcam_pkg::ADDR_ALARM0, 32'h0000_0003);
    ctrlNow = M_RUN | M_AEN | M_ARS;
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow);
    clear_pending();
    reg_read(rtcam_pkg::ADDR_CTRL, rd);
    check("flag not set by write", 32'(rd[2]), 32'h0000_0000);
    osc_cycles(6, flags);
    check("alarm events", 32'(flags), 32'h0000_0001);
    check("pending latched", 32'(irqPending), 32'h0000_0001);
    check("wake latched", 32'(wakeRequest), 32'h0000_0001);
    capture(v);
    check("auto-reset count", v, 32'h0000_0001);
    clear_pending();
    check("pending cleared", 32'(irqPending), 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      osc_cycles(1, flags);
      if (flags != 0) break;
    end
    check("flag seen again", 32'(flags), 32'h0000_0001);
    ctrlNow = M_RUN | M_ARS;
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow);
    reg_read(rtcam_pkg::ADDR_CTRL, rd);
    check("flag cleared by disable", 32'(rd[2]), 32'h0000_0000);
    ctrlNow = M_RUN;
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow);
    set_to(32'h0000_0004);
    ctrlNow = M_RUN | M_AEN;
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow);
    clear_pending();
    osc_cycles(4, flags);
    check("no early match", 32'(flags), 32'h0000_0000);
    check("no pending", 32'(irqPending), 32'h0000_0000);
  endtask : test_alarm
  task automatic test_missing;
    ctrlNow = M_OSC | M_MCD;
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow);
    clear_pending();
    check("osc enable out", 32'(oscEnable), 32'h0000_0001);
    reg_read(rtcam_pkg::ADDR_OSC, rd);
    check("valid blanked", 32'(rd[rtcam_pkg::BIT_XTAL_VALID]), 32'h0000_0000);
    repeat (rtcam_pkg::MISSING_CYCLES - 500) @(posedge clock);
    reg_read(rtcam_pkg::ADDR_CTRL, rd);
    check("fail not early", 32'(rd[5]), 32'h0000_0000);
    repeat (1000) @(posedge clock);
    reg_read(rtcam_pkg::ADDR_CTRL, rd);
    check("fail flagged", 32'(rd[5]), 32'h0000_0001);
    check("fail pending", 32'(irqPending), 32'h0000_0001);
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow);
    clear_pending();
    repeat (rtcam_pkg::MISSING_CYCLES + 500) @(posedge clock);
    reg_read(rtcam_pkg::ADDR_CTRL, rd);
    check("one-shot only", 32'(rd[5]), 32'h0000_0000);
    ctrlNow = M_OSC;
    reg_write(rtcam_pkg::ADDR_CTRL, ctrlNow);
    repeat (rtcam_pkg::MISSING_CYCLES + 500) @(posedge clock);
    reg_read(rtcam_pkg::ADDR_CTRL, rd);
    check("disabled detector", 32'(rd[5]), 32'h0000_0000);
    check("no fail pending", 32'(irqPending), 32'h0000_0000);
  endtask : test_missing
  // verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog against a hung handshake
  initial begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    test_reset();
    test_transfer();
    test_alarm();
    test_missing();
    tally_and_finish();
  end
endmodule : rtcam_top_tb
